// File: rtl/aeo_pkg.sv
// constants and types for the absolute encoder data output block
package aeo_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 125_000_000;
  localparam int unsigned POWER_ON_WAIT_MS  = 100;
  localparam int unsigned SETTLE_MS         = 400;
  localparam int unsigned BAUD_BPS          = 9600;
  localparam int unsigned POWER_ON_WAIT_CYC = (CLK_HZ / 1000) * POWER_ON_WAIT_MS;
  localparam int unsigned SETTLE_CYC        = (CLK_HZ / 1000) * SETTLE_MS;
  localparam int unsigned BIT_CYC           = CLK_HZ / BAUD_BPS;

  // ---------------------------------------------------------------
  // serial character format
  // ---------------------------------------------------------------
  localparam int unsigned CHAR_BITS  = 7;
  localparam int unsigned FRAME_BITS = 10;
  localparam int unsigned REV_CHARS  = 8;
  localparam int unsigned ALM_CHARS  = 7;
  localparam logic [6:0] CH_P     = 7'h50;
  localparam logic [6:0] CH_PLUS  = 7'h2b;
  localparam logic [6:0] CH_MINUS = 7'h2d;
  localparam logic [6:0] CH_CR    = 7'h0d;
  localparam logic [6:0] CH_A     = 7'h41;
  localparam logic [6:0] CH_L     = 7'h4c;
  localparam logic [6:0] CH_M     = 7'h4d;
  localparam logic [6:0] CH_DOT   = 7'h2e;
  localparam logic [6:0] CH_ZERO  = 7'h30;
  localparam logic [6:0] CH_HEX_A = 7'h37;

  // ---------------------------------------------------------------
  // pulse divider and initial pulse rate
  // ---------------------------------------------------------------
  localparam int unsigned PULSE_W          = 19;
  localparam int unsigned POS_W            = 21;
  localparam int unsigned EDGES_PER_PULSE  = 4;
  localparam int unsigned INIT_RATE_KPPS   = 680;
  localparam int unsigned INIT_EDGE_NUM    = INIT_RATE_KPPS * 1000 * EDGES_PER_PULSE;
  localparam int unsigned ENC_CPR_DEF      = 1_048_576;
  localparam logic [PULSE_W-1:0] BOUND_0   = 19'h04000;
  localparam logic [PULSE_W-1:0] BOUND_1   = 19'h08000;
  localparam logic [PULSE_W-1:0] BOUND_2   = 19'h10000;
  localparam logic [PULSE_W-1:0] BOUND_3   = 19'h20000;
  localparam logic [PULSE_W-1:0] BOUND_4   = 19'h40000;

  // ---------------------------------------------------------------
  // revolution count
  // ---------------------------------------------------------------
  localparam logic [15:0] MT_LIMIT_NONE = 16'hffff;
  localparam logic [15:0] REV_RESET     = 16'h0000;
  localparam int unsigned DIGITS        = 5;

  // ---------------------------------------------------------------
  // origin edge select
  // ---------------------------------------------------------------
  localparam logic [1:0] EDGE_A_RISE = 2'h0;
  localparam logic [1:0] EDGE_A_FALL = 2'h1;
  localparam logic [1:0] EDGE_B_RISE = 2'h2;
  localparam logic [1:0] EDGE_B_FALL = 2'h3;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_ON,
    ST_CONVERT,
    ST_SEND_REV,
    ST_SETTLE,
    ST_NORMAL,
    ST_SEND_ALM
  } aeo_state_e;

endpackage

// File: rtl/aeo_uart_tx.sv
// asynchronous character transmitter: start, 7 data, even parity, stop
`timescale 1ns/1ps
`default_nettype none
module aeo_uart_tx
  import aeo_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [6:0] data_i,
  output logic            line_o,
  output logic            busy_o
);

  logic [FRAME_BITS-1:0] shift_reg;
  logic [3:0]            bits_reg;
  logic [15:0]           cyc_reg;
  logic                  bit_end;

  assign bit_end = (cyc_reg == 16'(BIT_CYCLES - 1));
  assign line_o  = shift_reg[0];
  assign busy_o  = (bits_reg != 4'h0);

  // lsb first, parity follows data; idle line stays high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_reg <= '1;
      bits_reg  <= 4'h0;
      cyc_reg   <= 16'h0000;
    end else if (!busy_o) begin
      cyc_reg <= 16'h0000;
      if (start_i) begin
        shift_reg <= {1'b1, ^data_i, data_i, 1'b0};
        bits_reg  <= 4'(FRAME_BITS);
      end
    end else if (bit_end) begin
      cyc_reg   <= 16'h0000;
      shift_reg <= {1'b1, shift_reg[FRAME_BITS-1:1]};
      bits_reg  <= bits_reg - 4'h1;
    end else begin
      cyc_reg <= cyc_reg + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// File: rtl/aeo_abs_output.sv
// absolute encoder data output path: serial frames and quadrature pulses
`timescale 1ns/1ps
`default_nettype none
module aeo_abs_output
  import aeo_pkg::*;
#(
  parameter int unsigned ENC_CPR        = ENC_CPR_DEF,
  parameter int unsigned POWER_ON_CYCLES = POWER_ON_WAIT_CYC,
  parameter int unsigned SETTLE_CYCLES   = SETTLE_CYC,
  parameter int unsigned BIT_CYCLES      = BIT_CYC
) (
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        RESET_I,
  input  wire logic                        ENCODER_POWER_ON_CMD_I,
  input  wire logic                        ENCODER_POWER_OFF_CMD_I,
  input  wire logic                        MOTOR_POWER_ON_I,
  input  wire logic                        ABS_ENCODER_USED_I,
  input  wire logic                        ENC_STEP_I,
  input  wire logic                        ENC_FWD_I,
  input  wire logic [aeo_pkg::PULSE_W-1:0] OUTPUT_PULSE_COUNT_SETTING_I,
  input  wire logic [15:0]                 MULTITURN_LIMIT_SETTING_I,
  input  wire logic [1:0]                  ORIGIN_EDGE_SEL_I,
  input  wire logic [11:0]                 ALARM_CODE_I,
  output logic                             PHASE_A_SERIAL_OUT_O,
  output logic                             PHASE_B_OUT_O,
  output logic                             ORIGIN_PULSE_OUT_O,
  output logic                             ABS_NORMAL_O,
  output logic                             OFF_CMD_REFUSED_O
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  aeo_state_e              state_reg;
  aeo_state_e              state_next;
  logic [31:0]             timer_reg;
  logic [23:0]             div_acc_reg;
  logic [POS_W-1:0]        out_pos_reg;
  logic [POS_W-1:0]        emit_pos_reg;
  logic [15:0]             rev_reg;
  logic signed [POS_W+2:0] pend_reg;
  logic [47:0]             rate_acc_reg;
  logic [1:0]              quad_reg;
  logic                    armed_reg;
  logic                    origin_reg;
  logic                    ph_prev_reg;
  logic [16:0]             work_reg;
  logic [2:0]              dig_idx_reg;
  logic [3:0]              digit_reg [DIGITS];
  logic                    neg_reg;
  logic [3:0]              char_idx_reg;
  logic                    tx_start_reg;
  logic                    a_out_reg;
  logic                    b_out_reg;
  logic                    refused_reg;

  // ---------------------------------------------------------------
  // divider: encoder counts to output quadrature edges
  // ---------------------------------------------------------------
  wire [POS_W-1:0] pos_mod     = POS_W'({OUTPUT_PULSE_COUNT_SETTING_I, 2'b00});
  wire [23:0]      div_inc     = 24'({OUTPUT_PULSE_COUNT_SETTING_I, 2'b00});
  wire [23:0]      cpr         = 24'(ENC_CPR);
  wire [24:0]      acc_up      = {1'b0, div_acc_reg} + {1'b0, div_inc};
  wire             div_fwd     = ENC_STEP_I && ENC_FWD_I && (acc_up >= {1'b0, cpr});
  wire             div_rev     = ENC_STEP_I && !ENC_FWD_I && (div_acc_reg < div_inc);
  wire [23:0]      div_acc_nxt = !ENC_STEP_I ? div_acc_reg
                               : ENC_FWD_I  ? (div_fwd ? 24'(acc_up - {1'b0, cpr})
                                                       : 24'(acc_up))
                               : (div_rev ? 24'(div_acc_reg + cpr - div_inc)
                                          : 24'(div_acc_reg - div_inc));
  wire             pos_top     = (out_pos_reg == pos_mod - POS_W'(1));
  wire             pos_zero    = (out_pos_reg == '0);

  // ---------------------------------------------------------------
  // revolution count with optional turn limit
  // ---------------------------------------------------------------
  wire        limited = (MULTITURN_LIMIT_SETTING_I != MT_LIMIT_NONE);
  wire        rev_up  = div_fwd && pos_top;
  wire        rev_dn  = div_rev && pos_zero;
  wire [15:0] rev_inc = (limited && rev_reg == MULTITURN_LIMIT_SETTING_I) ? 16'h0000
                      : rev_reg + 16'h0001;
  wire [15:0] rev_dec = (limited && rev_reg == 16'h0000) ? MULTITURN_LIMIT_SETTING_I
                      : rev_reg - 16'h0001;

  // ---------------------------------------------------------------
  // initial pulse rate limiter
  // ---------------------------------------------------------------
  wire [PULSE_W-1:0] set   = OUTPUT_PULSE_COUNT_SETTING_I;
  wire [PULSE_W-1:0] bound = (set <= BOUND_0) ? BOUND_0
                           : (set <= BOUND_1) ? BOUND_1
                           : (set <= BOUND_2) ? BOUND_2
                           : (set <= BOUND_3) ? BOUND_3 : BOUND_4;
  wire [47:0] rate_add = 48'(set) * 48'(INIT_EDGE_NUM);
  wire [47:0] rate_thr = 48'(bound) * 48'(CLK_HZ);
  wire [47:0] rate_sum = rate_acc_reg + rate_add;
  wire        rate_tick = (rate_sum >= rate_thr);

  // ---------------------------------------------------------------
  // quadrature emission
  // ---------------------------------------------------------------
  wire emit_en   = (state_reg == ST_NORMAL) || (state_reg == ST_SETTLE && rate_tick);
  wire emit_fwd  = emit_en && (pend_reg > 0);
  wire emit_rev  = emit_en && (pend_reg < 0);
  wire emit_top  = (emit_pos_reg == pos_mod - POS_W'(1));
  wire emit_zero = (emit_pos_reg == '0);
  wire [1:0] quad_nxt = emit_fwd ? quad_reg + 2'h1
                      : emit_rev ? quad_reg - 2'h1 : quad_reg;
  // counting up gives 00,01,11,10 on (A,B): B changes first
  wire quad_a = quad_reg[1];
  wire quad_b = quad_reg[1] ^ quad_reg[0];
  wire cross_origin = (emit_fwd && emit_top) || (emit_rev && emit_zero);
  wire signed [POS_W+2:0] pend_step = (POS_W+3)'((div_fwd ? 1 : 0) - (div_rev ? 1 : 0)
                                    - (emit_fwd ? 1 : 0) + (emit_rev ? 1 : 0));

  // ---------------------------------------------------------------
  // origin pulse: width of one level of the selected phase, on the chosen edge
  // ---------------------------------------------------------------
  wire ph_now    = ORIGIN_EDGE_SEL_I[1] ? quad_b : quad_a;
  wire want_lvl  = (ORIGIN_EDGE_SEL_I == EDGE_A_RISE) || (ORIGIN_EDGE_SEL_I == EDGE_B_RISE);
  wire ph_edge   = (ph_now != ph_prev_reg);
  wire org_set   = armed_reg && ph_edge && (ph_now == want_lvl);
  wire org_clr   = origin_reg && ph_edge;

  // ---------------------------------------------------------------
  // decimal conversion of the revolution count
  // ---------------------------------------------------------------
  wire        rev_neg = !limited && rev_reg[15];
  wire [16:0] rev_mag = rev_neg ? 17'(-$signed({rev_reg[15], rev_reg})) : {1'b0, rev_reg};
  wire [16:0] pow10   = (dig_idx_reg == 3'h0) ? 17'd10000
                      : (dig_idx_reg == 3'h1) ? 17'd1000
                      : (dig_idx_reg == 3'h2) ? 17'd100
                      : (dig_idx_reg == 3'h3) ? 17'd10 : 17'd1;
  wire        sub_ok  = (work_reg >= pow10);
  wire        conv_done = (dig_idx_reg == 3'(DIGITS));

  // ---------------------------------------------------------------
  // character selection
  // ---------------------------------------------------------------
  wire [3:0] alm_hi  = ALARM_CODE_I[11:8];
  wire [3:0] alm_mid = ALARM_CODE_I[7:4];
  wire [6:0] hex_hi  = (alm_hi < 4'ha) ? CH_ZERO + 7'(alm_hi) : CH_HEX_A + 7'(alm_hi);
  wire [6:0] hex_mid = (alm_mid < 4'ha) ? CH_ZERO + 7'(alm_mid) : CH_HEX_A + 7'(alm_mid);
  wire [2:0] dsel    = 3'(char_idx_reg - 4'h2);
  wire [6:0] rev_ch  = (char_idx_reg == 4'h0) ? CH_P
                     : (char_idx_reg == 4'h1) ? (neg_reg ? CH_MINUS : CH_PLUS)
                     : (char_idx_reg == 4'h7) ? CH_CR
                     : CH_ZERO + 7'(digit_reg[dsel]);
  wire [6:0] alm_ch  = (char_idx_reg == 4'h0) ? CH_A
                     : (char_idx_reg == 4'h1) ? CH_L
                     : (char_idx_reg == 4'h2) ? CH_M
                     : (char_idx_reg == 4'h3) ? hex_hi
                     : (char_idx_reg == 4'h4) ? hex_mid
                     : (char_idx_reg == 4'h5) ? CH_DOT : CH_CR;
  wire       sending = (state_reg == ST_SEND_REV) || (state_reg == ST_SEND_ALM);
  wire [3:0] n_chars = (state_reg == ST_SEND_REV) ? 4'(REV_CHARS) : 4'(ALM_CHARS);
  wire       tx_line;
  wire       tx_busy;
  wire       tx_go    = sending && !tx_busy && !tx_start_reg;
  wire       tx_fire  = tx_go && (char_idx_reg < n_chars);
  wire       tx_done  = tx_go && (char_idx_reg == n_chars);

  aeo_uart_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RESET_I),
    .start_i (tx_start_reg),
    .data_i  ((state_reg == ST_SEND_ALM) ? alm_ch : rev_ch),
    .line_o  (tx_line),
    .busy_o  (tx_busy)
  );

  // ---------------------------------------------------------------
  // sequence control
  // ---------------------------------------------------------------
  wire off_req  = ENCODER_POWER_OFF_CMD_I && (state_reg != ST_OFF);
  wire off_ok   = off_req && !MOTOR_POWER_ON_I;
  wire wait_end = (timer_reg == POWER_ON_CYCLES - 1);
  wire set_end  = (timer_reg == SETTLE_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (ENCODER_POWER_ON_CMD_I) state_next = ST_WAIT_ON;
      end
      ST_WAIT_ON: begin
        if (wait_end) state_next = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (conv_done) state_next = ST_SEND_REV;
      end
      ST_SEND_REV: begin
        if (tx_done) state_next = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (set_end) state_next = ST_NORMAL;
      end
      ST_NORMAL: begin
        state_next = ST_NORMAL;
      end
      ST_SEND_ALM: begin
        if (tx_done) state_next = ST_OFF;
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (off_ok && state_reg != ST_SEND_ALM) begin
      state_next = ABS_ENCODER_USED_I ? ST_SEND_ALM : ST_OFF;
    end
  end

  wire standby = (state_reg == ST_WAIT_ON) && wait_end;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      state_reg <= ST_OFF;
      timer_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      timer_reg <= (state_next != state_reg) ? 32'h0000_0000 : timer_reg + 32'h0000_0001;
    end
  end

  // position tracking runs regardless of power state
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      div_acc_reg <= 24'h00_0000;
      out_pos_reg <= '0;
      rev_reg     <= REV_RESET;
    end else begin
      div_acc_reg <= div_acc_nxt;
      if (div_fwd) out_pos_reg <= pos_top ? '0 : out_pos_reg + POS_W'(1);
      if (div_rev) out_pos_reg <= pos_zero ? pos_mod - POS_W'(1) : out_pos_reg - POS_W'(1);
      if (rev_up) rev_reg <= rev_inc;
      if (rev_dn) rev_reg <= rev_dec;
    end
  end

  // standby clears the host reference: outputs restart from zero
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      pend_reg     <= '0;
      emit_pos_reg <= '0;
      quad_reg     <= 2'h0;
      rate_acc_reg <= 48'h0000_0000_0000;
    end else if (standby) begin
      pend_reg     <= (POS_W+3)'(out_pos_reg);
      emit_pos_reg <= '0;
      quad_reg     <= 2'h0;
      rate_acc_reg <= 48'h0000_0000_0000;
    end else if (state_reg == ST_OFF) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= pend_reg + pend_step;
      quad_reg <= quad_nxt;
      if (emit_fwd) emit_pos_reg <= emit_top ? '0 : emit_pos_reg + POS_W'(1);
      if (emit_rev) emit_pos_reg <= emit_zero ? pos_mod - POS_W'(1) : emit_pos_reg - POS_W'(1);
      if (state_reg == ST_SETTLE) rate_acc_reg <= rate_tick ? rate_sum - rate_thr : rate_sum;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      armed_reg   <= 1'b0;
      origin_reg  <= 1'b0;
      ph_prev_reg <= 1'b0;
    end else begin
      ph_prev_reg <= ph_now;
      if (cross_origin) armed_reg <= 1'b1;
      else if (org_set) armed_reg <= 1'b0;
      if (org_set) origin_reg <= 1'b1;
      else if (org_clr) origin_reg <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      work_reg    <= 17'h0_0000;
      dig_idx_reg <= 3'h0;
      neg_reg     <= 1'b0;
      for (int i = 0; i < DIGITS; i++) digit_reg[i] <= 4'h0;
    end else if (standby) begin
      work_reg    <= rev_mag;
      neg_reg     <= rev_neg;
      dig_idx_reg <= 3'h0;
      for (int i = 0; i < DIGITS; i++) digit_reg[i] <= 4'h0;
    end else if (state_reg == ST_CONVERT && !conv_done) begin
      if (sub_ok) begin
        work_reg <= work_reg - pow10;
        digit_reg[dig_idx_reg] <= digit_reg[dig_idx_reg] + 4'h1;
      end else begin
        dig_idx_reg <= dig_idx_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      char_idx_reg <= 4'h0;
      tx_start_reg <= 1'b0;
    end else begin
      tx_start_reg <= tx_fire;
      // advance once the transmitter has taken the char, so data_i still shows it
      if (!sending || state_next != state_reg) char_idx_reg <= 4'h0;
      else if (tx_start_reg) char_idx_reg <= char_idx_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  wire quad_phase = (state_reg == ST_SETTLE) || (state_reg == ST_NORMAL);

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      a_out_reg   <= 1'b1;
      b_out_reg   <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      a_out_reg   <= quad_phase ? quad_a : tx_line;
      b_out_reg   <= quad_b;
      refused_reg <= off_req && MOTOR_POWER_ON_I;
    end
  end

  assign PHASE_A_SERIAL_OUT_O = a_out_reg;
  assign PHASE_B_OUT_O        = b_out_reg;
  assign ORIGIN_PULSE_OUT_O   = origin_reg;
  assign OFF_CMD_REFUSED_O    = refused_reg;

  logic normal_reg;
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) normal_reg <= 1'b0;
    else normal_reg <= (state_reg == ST_NORMAL);
  end
  assign ABS_NORMAL_O = normal_reg;

endmodule
`default_nettype wire

// File: tb/aeo_abs_output_asserts.sv
// port-level assertion checker for the absolute encoder output path
`timescale 1ns/1ps
`default_nettype none
module aeo_abs_output_asserts
  import aeo_pkg::*;
#(
  parameter int ON_CYC = 200,
  parameter int BIT    = 8
) (
  input wire logic       CORE_CLK_I,
  input wire logic       RESET_I,
  input wire logic       ENCODER_POWER_ON_CMD_I,
  input wire logic       ENCODER_POWER_OFF_CMD_I,
  input wire logic       MOTOR_POWER_ON_I,
  input wire logic       ABS_ENCODER_USED_I,
  input wire logic       ENC_FWD_I,
  input wire logic [1:0] ORIGIN_EDGE_SEL_I,
  input wire logic       PHASE_A_SERIAL_OUT_O,
  input wire logic       PHASE_B_OUT_O,
  input wire logic       ORIGIN_PULSE_OUT_O,
  input wire logic       ABS_NORMAL_O,
  input wire logic       OFF_CMD_REFUSED_O
);
  localparam int LO = ON_CYC;
  localparam int HI = ON_CYC + 80;
  logic off_reg, in_alarm_reg, fall_al_reg;
  int   wait_reg, low_reg;
  wire  a_l    = PHASE_A_SERIAL_OUT_O;
  wire  b_l    = PHASE_B_OUT_O;
  wire  on_go  = ENCODER_POWER_ON_CMD_I && off_reg;
  wire  alm_go = ENCODER_POWER_OFF_CMD_I && !MOTOR_POWER_ON_I && ABS_NORMAL_O && ABS_ENCODER_USED_I;
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  // rough mirror of the command flow; only one power-on per reset is tracked
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      off_reg      <= 1'h1;
      in_alarm_reg <= 1'h0;
      fall_al_reg  <= 1'h0;
      wait_reg     <= 0;
      low_reg      <= 0;
    end else begin
      off_reg      <= off_reg && !ENCODER_POWER_ON_CMD_I;
      in_alarm_reg <= (in_alarm_reg || alm_go) && !ENCODER_POWER_ON_CMD_I;
      wait_reg     <= on_go ? ON_CYC : (wait_reg > 0 ? wait_reg - 1 : 0);
      low_reg      <= a_l ? 0 : low_reg + 1;
      if (!a_l && low_reg == 0) fall_al_reg <= in_alarm_reg;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence frame_start;
    ##[LO:HI] $fell(a_l);
  endsequence
  chk_refuse_pulse: assert property (
    ENCODER_POWER_OFF_CMD_I && MOTOR_POWER_ON_I && ABS_NORMAL_O |=> OFF_CMD_REFUSED_O)
    else $error("refusal flag missing");
  chk_refuse_cause: assert property (
    OFF_CMD_REFUSED_O |-> $past(ENCODER_POWER_OFF_CMD_I) && $past(MOTOR_POWER_ON_I))
    else $error("refusal flag without cause");
  chk_refuse_keep: assert property (
    OFF_CMD_REFUSED_O && $past(ABS_NORMAL_O) |-> ABS_NORMAL_O)
    else $error("refused command changed mode");
  chk_quad_gray: assert property (
    ABS_NORMAL_O && $past(ABS_NORMAL_O) |-> !($changed(a_l) && $changed(b_l)))
    else $error("both phases moved together");
  chk_fwd_lead: assert property (
    ABS_NORMAL_O && ENC_FWD_I && $changed(a_l) |-> a_l == b_l)
    else $error("phase b not leading");
  chk_origin_edge: assert property (
    $rose(ORIGIN_PULSE_OUT_O) |->
      (ORIGIN_EDGE_SEL_I == EDGE_A_RISE && $rose(a_l)) || (ORIGIN_EDGE_SEL_I == EDGE_A_FALL && $fell(a_l))
      || (ORIGIN_EDGE_SEL_I == EDGE_B_RISE && $rose(b_l)) || (ORIGIN_EDGE_SEL_I == EDGE_B_FALL && $fell(b_l)))
    else $error("origin pulse off its edge");
  chk_wait_high: assert property (
    wait_reg != 0 |-> a_l)
    else $error("line active during power-on wait");
  chk_frame_start: assert property (
    on_go |-> frame_start)
    else $error("frame did not start after wait");
  chk_bit_width: assert property (
    $rose(a_l) && fall_al_reg |-> low_reg % BIT == 0)
    else $error("serial bit width wrong");
endmodule
bind aeo_abs_output aeo_abs_output_asserts #(.ON_CYC(POWER_ON_CYCLES), .BIT(BIT_CYCLES)) u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .ENCODER_POWER_ON_CMD_I(ENCODER_POWER_ON_CMD_I),
  .ENCODER_POWER_OFF_CMD_I(ENCODER_POWER_OFF_CMD_I), .MOTOR_POWER_ON_I(MOTOR_POWER_ON_I),
  .ABS_ENCODER_USED_I(ABS_ENCODER_USED_I), .ENC_FWD_I(ENC_FWD_I),
  .ORIGIN_EDGE_SEL_I(ORIGIN_EDGE_SEL_I), .PHASE_A_SERIAL_OUT_O(PHASE_A_SERIAL_OUT_O),
  .PHASE_B_OUT_O(PHASE_B_OUT_O), .ORIGIN_PULSE_OUT_O(ORIGIN_PULSE_OUT_O),
  .ABS_NORMAL_O(ABS_NORMAL_O), .OFF_CMD_REFUSED_O(OFF_CMD_REFUSED_O)
);
`default_nettype wire

// File: tb/aeo_host_rx.sv
// host-side serial receiver model for the a line
`timescale 1ns/1ps
`default_nettype none
module aeo_host_rx #(
  parameter int BIT = 8
) (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic       line_i,
  output logic [6:0]      char_o,
  output logic            par_ok_o,
  output int              count_o
);
  logic [7:0] sh;
  initial begin
    char_o   = 7'h00;
    par_ok_o = 1'h0;
    count_o  = 0;
    forever begin
      @(negedge line_i iff en_i);
      // sample mid-bit so a registered line edge never races the sample
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_i);
        sh[i] = line_i;
      end
      repeat (BIT) @(posedge clk_i);
      char_o   = sh[6:0];
      par_ok_o = (^sh == 1'h0) && line_i;
      count_o  = count_o + 1;
    end
  end
endmodule
`default_nettype wire

// File: tb/test_absolute_encoder_data_output.sv
// self-checking bench for the absolute encoder data output path
`timescale 1ns/1ps
`default_nettype none
module test_absolute_encoder_data_output;
  import aeo_pkg::*;
  logic       clk = 1'h0, rst = 1'h1, on_cmd = 1'h0, off_cmd = 1'h0, motor = 1'h0;
  logic       abs_used = 1'h1, step = 1'h0, fwd = 1'h1, rx_en = 1'h0, mon = 1'h0;
  logic [1:0] sel = 2'h0;
  logic [18:0] pset = 19'h00010;
  logic [15:0] lim  = 16'hffff;
  logic [11:0] alm  = 12'h51a;
  logic       a, b, c, nrm, refused, rx_ok;
  logic [6:0] rx_char;
  int         rx_n, ra, rc, hc, base, failures = 0, samples_checked = 0, cyc = 0;
  always #4 clk = ~clk;
  aeo_abs_output #(.ENC_CPR(64), .POWER_ON_CYCLES(200), .SETTLE_CYCLES(300), .BIT_CYCLES(8)) uut (
    .CORE_CLK_I(clk), .RESET_I(rst), .ENCODER_POWER_ON_CMD_I(on_cmd),
    .ENCODER_POWER_OFF_CMD_I(off_cmd), .MOTOR_POWER_ON_I(motor), .ABS_ENCODER_USED_I(abs_used),
    .ENC_STEP_I(step), .ENC_FWD_I(fwd), .OUTPUT_PULSE_COUNT_SETTING_I(pset),
    .MULTITURN_LIMIT_SETTING_I(lim), .ORIGIN_EDGE_SEL_I(sel), .ALARM_CODE_I(alm),
    .PHASE_A_SERIAL_OUT_O(a), .PHASE_B_OUT_O(b), .ORIGIN_PULSE_OUT_O(c), .ABS_NORMAL_O(nrm),
    .OFF_CMD_REFUSED_O(refused));
  aeo_host_rx #(.BIT(8)) host (.clk_i(clk), .en_i(rx_en), .line_i(a), .char_o(rx_char),
    .par_ok_o(rx_ok), .count_o(rx_n));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task get_frame(input int n, input logic [6:0] want [8]);
    base = rx_n;
    for (int k = 0; k < n; k++) begin
      while (rx_n <= base + k) tick(1);
      check((k == 1 && rx_char === CH_MINUS) ? CH_PLUS : rx_char, want[k]);
      check(rx_ok, 1'h1);
    end
  endtask
  task test_done;
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // host counters are never cleared from the origin line
  always @(posedge clk) if (mon) begin
    ra += $rose(a);
    rc += $rose(c);
    hc += c;
  end
  always @(posedge clk) if (++cyc == 20000) begin
    failures++;
    test_done;
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_rev_frame;
    rx_en = 1'h1;
    on_cmd = 1'h1;
    tick(1);
    on_cmd = 1'h0;
    get_frame(8, '{CH_P, CH_PLUS, CH_ZERO, CH_ZERO, CH_ZERO, CH_ZERO, CH_ZERO, CH_CR});
    rx_en = 1'h0;
  endtask
  task t_origin;
    while (!nrm) tick(1);
    step = 1'h1;
    tick(32);
    step = 1'h0;
    tick(8);
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      {ra, rc, hc} = '0;
      mon = 1'h1;
      step = 1'h1;
      tick(64);
      step = 1'h0;
      tick(8);
      mon = 1'h0;
      check(ra, 16);
      check(rc, 1);
      check(hc, 2);
    end
  endtask
  task t_refuse;
    motor = 1'h1;
    off_cmd = 1'h1;
    tick(1);
    off_cmd = 1'h0;
    check(refused, 1'h1);
    tick(2);
    check(nrm, 1'h1);
    motor = 1'h0;
  endtask
  task t_alarm;
    rx_en = 1'h1;
    off_cmd = 1'h1;
    tick(1);
    off_cmd = 1'h0;
    get_frame(7, '{CH_A, CH_L, CH_M, 7'h35, 7'h31, CH_DOT, CH_CR, 7'h00});
    check(nrm, 1'h0);
  endtask
  task t_again;
    tick(8);
    lim = 16'h0004;
    step = 1'h1;
    tick(128);
    step = 1'h0;
    on_cmd = 1'h1;
    tick(1);
    on_cmd = 1'h0;
    get_frame(8, '{CH_P, CH_PLUS, CH_ZERO, CH_ZERO, CH_ZERO, CH_ZERO, 7'h31, CH_CR});
    rx_en = 1'h0;
    {ra, rc, hc} = '0;
    mon = 1'h1;
    while (!nrm) tick(1);
    tick(40);
    mon = 1'h0;
    check(ra, 8);
    check(1 * 16 + ra, 24);
    check(-1 * 16 + ra, -8);
    abs_used = 1'h0;
    off_cmd = 1'h1;
    tick(1);
    off_cmd = 1'h0;
    tick(5);
    check(a, 1'h1);
    check(nrm, 1'h0);
  endtask
  initial begin
    tick(4);
    rst = 1'h0;
    t_rev_frame;
    t_origin;
    t_refuse;
    t_alarm;
    t_again;
    test_done;
  end
endmodule
`default_nettype wire
